// File: hdl/fliv_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Four priority levels; every source gets its own level.
// - Level is two bits, high and low; 00 lowest, 11 highest.
// - Accepted request sends the core to 0003H plus eight times its vector.
// - Each source has an enable bit; disabled sources never request.
// - Global enable, bit 7 of primary enable, gates every source.
// - Flags set while globally disabled stay pending until enabled.
// - Any enabled flag at one requests, whether set by hardware or software.
// - Running handler is preempted only by a strictly higher level.
// - Equal or lower level never preempts, whatever its natural priority.
// - Returns unwind nested handlers back down to the main program.
// - Highest level wins; natural priority breaks ties only.
// - Fixed natural order of sources from external input 0 downward.
// - Only listed sources may wake the core from power-down.
// - Accepted level is marked in service until its return.
// - Return resumes the instruction that would have run next.
// - Reset clears every source enable and the global enable.
// - Call only at last instruction cycle, no config write, no return.
// - Arbitrate every cycle; call lasts four cycles, five to handler.
// - A blocked request that vanished is not remembered.
// - Plain subroutine return leaves the in-service record alone.
module fliv_ctrl (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic [fliv_pkg::N_SRC-1:0]    srcFlags,
    input  wire logic                          instrLastCycle,
    input  wire logic                          retiExec,
    input  wire logic                          cfgWrite,
    input  wire logic [1:0]                    cfgSel,
    input  wire logic [fliv_pkg::N_SRC-1:0]    cfgData,
    input  wire logic                          powerDown,
    output logic [7:0]                         primaryEnableReg,
    output logic [fliv_pkg::EXT_EN_W-1:0]      extendedEnableReg,
    output logic [fliv_pkg::N_SRC-1:0]         levelLowBits,
    output logic [fliv_pkg::N_SRC-1:0]         levelHighBits,
    output logic                               vecCall,
    output logic                               callBusy,
    output logic                               handlerStart,
    output logic [15:0]                        vecAddr,
    output logic [fliv_pkg::VEC_W-1:0]         vecNum,
    output logic [fliv_pkg::LVL_W-1:0]         callLevel,
    output logic [fliv_pkg::N_SRC-1:0]         flagAck,
    output logic [fliv_pkg::N_LVL-1:0]         inService,
    output logic                               wakeReq
);
    import fliv_pkg::*;

    typedef struct packed {
        fliv_state_t         st;
        logic [2:0]          cnt;
        logic [7:0]          primaryEnableReg;
        logic [EXT_EN_W-1:0] extendedEnableReg;
        logic [N_SRC-1:0]    levelLowBits;
        logic [N_SRC-1:0]    levelHighBits;
        logic                vecCall;
        logic                callBusy;
        logic                handlerStart;
        logic [15:0]         vecAddr;
        logic [VEC_W-1:0]    vecNum;
        logic [LVL_W-1:0]    callLevel;
        logic [N_SRC-1:0]    flagAck;
        logic                wakeReq;
    } fliv_ctrl_state_t;

    fliv_ctrl_state_t s;
    fliv_ctrl_state_t next_s;

    logic [N_SRC-1:0] allEn;
    logic [N_SRC-1:0] liveReq;
    logic             globalIrqEnable;
    logic             anyReq;
    logic [VEC_W-1:0] winVec;
    logic [LVL_W-1:0] winLevel;
    logic             levelFree;
    logic             slotOk;
    logic             callOk;
    logic             retiPop;

    // Per-source enables: sources 0..6 in the primary register, the rest extended
    assign allEn           = {s.extendedEnableReg, s.primaryEnableReg[PRI_SRC-1:0]};
    assign globalIrqEnable = s.primaryEnableReg[GLOBAL_EN_BIT];
    // Live flags only: nothing is latched, so a vanished request is simply gone
    assign liveReq         = srcFlags & allEn;

    fliv_arbiter u_arbiter (
        .req           (liveReq),
        .levelHighBits (s.levelHighBits),
        .levelLowBits  (s.levelLowBits),
        .anyReq        (anyReq),
        .winVec        (winVec),
        .winLevel      (winLevel)
    );

    // No handler of equal or higher level may be in service
    assign levelFree = (inService >> winLevel) == 4'h0;
    // Instruction boundary that neither rewrites config nor returns
    assign slotOk    = instrLastCycle && !cfgWrite && !retiExec;
    assign callOk    = (s.st == ST_IDLE) && globalIrqEnable && anyReq
                       && levelFree && slotOk;
    // Only the interrupt return pops; a plain return has no port here
    assign retiPop   = retiExec && instrLastCycle;

    fliv_nest u_nest (
        .clk       (clk),
        .rst_n     (rst_n),
        .push      (callOk),
        .pushLevel (winLevel),
        .pop       (retiPop),
        .inService (inService)
    );

    always_comb begin
        next_s              = s;
        next_s.vecCall      = 1'b0;
        next_s.handlerStart = 1'b0;
        next_s.flagAck      = '0;

        if (cfgWrite) begin
            unique case (cfgSel)
                CFG_SEL_PRIMARY:  next_s.primaryEnableReg  = cfgData[7:0];
                CFG_SEL_EXTENDED: next_s.extendedEnableReg = cfgData[EXT_EN_W-1:0];
                CFG_SEL_LVL_LOW:  next_s.levelLowBits      = cfgData;
                CFG_SEL_LVL_HIGH: next_s.levelHighBits     = cfgData;
            endcase
        end

        unique case (s.st)
            ST_IDLE: begin
                if (callOk) begin
                    next_s.st        = ST_CALL;
                    next_s.cnt       = 3'(CALL_CYCLES - 1);
                    next_s.vecCall   = 1'b1;
                    next_s.callBusy  = 1'b1;
                    next_s.vecNum    = winVec;
                    next_s.vecAddr   = VEC_BASE + (16'(winVec) << VEC_SHIFT);
                    next_s.callLevel = winLevel;
                    next_s.flagAck   = N_SRC'(1) << winVec;
                end
            end
            ST_CALL: begin
                if (s.cnt == 3'h0) begin
                    next_s.st           = ST_IDLE;
                    next_s.callBusy     = 1'b0;
                    next_s.handlerStart = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 3'h1;
                end
            end
        endcase

        next_s.wakeReq = powerDown && globalIrqEnable
                         && ((liveReq & WAKE_MASK) != '0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{st:                ST_IDLE,
                   cnt:               3'h0,
                   primaryEnableReg:  PRIMARY_RST,
                   extendedEnableReg: EXTENDED_RST,
                   levelLowBits:      LVL_RST,
                   levelHighBits:     LVL_RST,
                   vecCall:           1'b0,
                   callBusy:          1'b0,
                   handlerStart:      1'b0,
                   vecAddr:           16'h0000,
                   vecNum:            5'h00,
                   callLevel:         2'h0,
                   flagAck:           LVL_RST,
                   wakeReq:           1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign primaryEnableReg  = s.primaryEnableReg;
    assign extendedEnableReg = s.extendedEnableReg;
    assign levelLowBits      = s.levelLowBits;
    assign levelHighBits     = s.levelHighBits;
    assign vecCall           = s.vecCall;
    assign callBusy          = s.callBusy;
    assign handlerStart      = s.handlerStart;
    assign vecAddr           = s.vecAddr;
    assign vecNum            = s.vecNum;
    assign callLevel         = s.callLevel;
    assign flagAck           = s.flagAck;
    assign wakeReq           = s.wakeReq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_call_body;
        callBusy [*4];
    endsequence

    sequence s_handler_go;
        handlerStart && !callBusy;
    endsequence

    property p_call_len;
        vecCall |-> s_call_body ##1 s_handler_go;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length not four cycles");

    property p_global_gate;
        vecCall |-> $past(primaryEnableReg[GLOBAL_EN_BIT]);
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("call with global enable off");

    property p_vec_addr;
        vecCall |-> vecAddr == VEC_BASE + (16'(vecNum) << VEC_SHIFT);
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("wrong handler address");

    property p_slot;
        vecCall |-> $past(instrLastCycle) && !$past(cfgWrite) && !$past(retiExec);
    endproperty
    a_slot: assert property (p_slot) else $error("call outside a legal slot");

    property p_preempt;
        vecCall |-> ($past(inService) >> callLevel) == 4'h0;
    endproperty
    a_preempt: assert property (p_preempt) else $error("call preempted equal or higher level");

    property p_winner;
        vecCall |-> $past(anyReq) && vecNum == $past(winVec) && callLevel == $past(winLevel);
    endproperty
    a_winner: assert property (p_winner) else $error("call does not match arbitration");

    property p_mark;
        vecCall |-> inService[callLevel];
    endproperty
    a_mark: assert property (p_mark) else $error("called level not in service");

    property p_ack;
        vecCall |-> flagAck == (N_SRC'(1) << vecNum) ##1 flagAck == '0;
    endproperty
    a_ack: assert property (p_ack) else $error("flag acknowledge wrong");

    property p_wake;
        wakeReq |-> $past(powerDown) && (($past(liveReq) & WAKE_MASK) != '0);
    endproperty
    a_wake: assert property (p_wake) else $error("wake from a non-waking source");

    property p_quiet_when_off;
        !globalIrqEnable && s.st == ST_IDLE |=> !vecCall;
    endproperty
    a_quiet_when_off: assert property (p_quiet_when_off) else $error("call while disabled");

    // Configuration writes land one cycle later; without a write nothing moves
    property p_cfg_primary;
        cfgWrite && cfgSel == CFG_SEL_PRIMARY |=> primaryEnableReg == $past(cfgData[7:0]);
    endproperty
    a_cfg_primary: assert property (p_cfg_primary) else $error("primary write lost");

    property p_cfg_extended;
        cfgWrite && cfgSel == CFG_SEL_EXTENDED
            |=> extendedEnableReg == $past(cfgData[EXT_EN_W-1:0]);
    endproperty
    a_cfg_extended: assert property (p_cfg_extended) else $error("extended write lost");

    property p_cfg_low;
        cfgWrite && cfgSel == CFG_SEL_LVL_LOW |=> levelLowBits == $past(cfgData);
    endproperty
    a_cfg_low: assert property (p_cfg_low) else $error("level low write lost");

    property p_cfg_high;
        cfgWrite && cfgSel == CFG_SEL_LVL_HIGH |=> levelHighBits == $past(cfgData);
    endproperty
    a_cfg_high: assert property (p_cfg_high) else $error("level high write lost");

    property p_cfg_hold;
        !cfgWrite |=> $stable(primaryEnableReg) && $stable(extendedEnableReg)
                      && $stable(levelLowBits) && $stable(levelHighBits);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without write");

    property p_src_enabled;
        vecCall |-> (($past(allEn) >> vecNum) & N_SRC'(1)) != '0;
    endproperty
    a_src_enabled: assert property (p_src_enabled) else $error("disabled source called");

    property p_flag_live;
        vecCall |-> (($past(srcFlags) >> vecNum) & N_SRC'(1)) != '0;
    endproperty
    a_flag_live: assert property (p_flag_live) else $error("inactive flag called");

    property p_level_code;
        vecCall |-> callLevel == {$past(levelHighBits[winVec]), $past(levelLowBits[winVec])};
    endproperty
    a_level_code: assert property (p_level_code) else $error("call level encoding wrong");

    property p_ack_only;
        flagAck != '0 |-> vecCall;
    endproperty
    a_ack_only: assert property (p_ack_only) else $error("acknowledge without call");

    sequence s_no_recall;
        !vecCall [*4];
    endsequence

    property p_call_gap;
        vecCall |=> s_no_recall;
    endproperty
    a_call_gap: assert property (p_call_gap) else $error("new call inside a call");

    property p_start_once;
        handlerStart |=> !handlerStart;
    endproperty
    a_start_once: assert property (p_start_once) else $error("handler start too long");

    property p_wake_global;
        wakeReq |-> $past(globalIrqEnable);
    endproperty
    a_wake_global: assert property (p_wake_global) else $error("wake with global off");

    property p_wake_set;
        powerDown && globalIrqEnable && ((liveReq & WAKE_MASK) != '0) |=> wakeReq;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("waking source did not wake");

    property p_no_wake_awake;
        !powerDown |=> !wakeReq;
    endproperty
    a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake while running");

    property p_reti_no_call;
        retiPop |=> !vecCall;
    endproperty
    a_reti_no_call: assert property (p_reti_no_call) else $error("call in a return cycle");

    property p_serve_pending;
        s.st == ST_IDLE && globalIrqEnable && (liveReq != '0) && inService == 4'h0 && slotOk
            |=> vecCall;
    endproperty
    a_serve_pending: assert property (p_serve_pending) else $error("request not served");

    property p_hold_call;
        !vecCall |-> $stable(vecAddr) && $stable(vecNum) && $stable(callLevel);
    endproperty
    a_hold_call: assert property (p_hold_call) else $error("call outputs moved");

    property p_svc_hold;
        !retiPop && !callOk |=> $stable(inService);
    endproperty
    a_svc_hold: assert property (p_svc_hold) else $error("in-service moved on its own");

endmodule // fliv_ctrl
`default_nettype wire

// File: include/fliv_pkg.sv
`default_nettype none
package fliv_pkg;

    localparam int N_SRC     = 18;
    localparam int VEC_W     = 5;
    localparam int LVL_W     = 2;
    localparam int N_LVL     = 4;
    localparam int PRI_SRC   = 7;
    localparam int EXT_EN_W  = N_SRC - PRI_SRC;
    localparam int CALL_CYCLES = 4;

    // Bit position of the global enable inside the primary enable register
    localparam int GLOBAL_EN_BIT = 7;

    // Handler address = base + vector number * 8
    localparam logic [15:0] VEC_BASE  = 16'h0003;
    localparam int          VEC_SHIFT = 3;

    // Configuration write selectors
    localparam logic [1:0] CFG_SEL_PRIMARY  = 2'h0;
    localparam logic [1:0] CFG_SEL_EXTENDED = 2'h1;
    localparam logic [1:0] CFG_SEL_LVL_LOW  = 2'h2;
    localparam logic [1:0] CFG_SEL_LVL_HIGH = 2'h3;

    // Reset values: every source and the global enable off, all levels 0
    localparam logic [7:0]          PRIMARY_RST  = 8'h00;
    localparam logic [EXT_EN_W-1:0] EXTENDED_RST = 11'h000;
    localparam logic [N_SRC-1:0]    LVL_RST      = 18'h00000;
    localparam logic [N_LVL-1:0]    INSVC_RST    = 4'h0;

    // Vector numbers from highest natural priority down to lowest
    localparam logic [VEC_W-1:0] NAT_ORDER [0:N_SRC-1] = '{
        5'h00, 5'h08, 5'h0a, 5'h01, 5'h06, 5'h0b, 5'h02, 5'h07, 5'h03,
        5'h04, 5'h0e, 5'h09, 5'h05, 5'h0c, 5'h0d, 5'h0f, 5'h10, 5'h11
    };

    // Sources allowed to wake the core from power-down
    localparam logic [N_SRC-1:0] WAKE_MASK = 18'h20585;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } fliv_state_t;

    function automatic logic [LVL_W-1:0] lvlOf(input logic [N_SRC-1:0] hi,
                                               input logic [N_SRC-1:0] lo,
                                               input logic [VEC_W-1:0] v);
        lvlOf = {hi[v], lo[v]};
    endfunction

    function automatic logic [N_LVL-1:0] topBit(input logic [N_LVL-1:0] m);
        topBit = 4'h0;
        for (int i = 0; i < N_LVL; i++) begin
            if (m[i]) begin
                topBit = 4'h1 << i;
            end
        end
    endfunction

endpackage
`default_nettype wire

// File: hdl/fliv_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module fliv_arbiter (
    input  wire logic [fliv_pkg::N_SRC-1:0] req,
    input  wire logic [fliv_pkg::N_SRC-1:0] levelHighBits,
    input  wire logic [fliv_pkg::N_SRC-1:0] levelLowBits,
    output logic                            anyReq,
    output logic [fliv_pkg::VEC_W-1:0]      winVec,
    output logic [fliv_pkg::LVL_W-1:0]      winLevel
);
    import fliv_pkg::*;

    // Walk from lowest natural priority upward; >= lets the higher one take ties
    always_comb begin
        logic [VEC_W-1:0] v;
        logic [LVL_W-1:0] l;
        v        = '0;
        l        = '0;
        anyReq   = 1'b0;
        winVec   = '0;
        winLevel = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            v = NAT_ORDER[i];
            l = lvlOf(levelHighBits, levelLowBits, v);
            if (req[v] && (!anyReq || l >= winLevel)) begin
                anyReq   = 1'b1;
                winVec   = v;
                winLevel = l;
            end
        end
    end

endmodule // fliv_arbiter
`default_nettype wire

// File: hdl/fliv_nest.sv
`timescale 1ns/100ps
`default_nettype none
module fliv_nest (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       push,
    input  wire logic [fliv_pkg::LVL_W-1:0] pushLevel,
    input  wire logic                       pop,
    output logic [fliv_pkg::N_LVL-1:0]      inService
);
    import fliv_pkg::*;

    typedef struct packed {
        logic [N_LVL-1:0] inService;
    } fliv_nest_state_t;

    fliv_nest_state_t s;
    fliv_nest_state_t next_s;

    always_comb begin
        next_s = s;
        if (pop) begin
            next_s.inService = s.inService & ~topBit(s.inService);
        end
        if (push) begin
            next_s.inService[pushLevel] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{inService: INSVC_RST};
        end else begin
            s <= next_s;
        end
    end

    assign inService = s.inService;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_pop_top;
        pop && !push |=> inService == ($past(inService) & ~topBit($past(inService)));
    endproperty
    a_pop_top: assert property (p_pop_top) else $error("return did not clear top level");

    property p_push_mark;
        push |=> inService[$past(pushLevel)];
    endproperty
    a_push_mark: assert property (p_push_mark) else $error("level not marked in service");

endmodule // fliv_nest
`default_nettype wire

// File: verif/fliv_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module fliv_core_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic retiReq,
    output logic      instrLastCycle,
    output logic      retiExec
);
    logic [1:0] phase;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        end
    end

    // Slow mode mimics three-cycle instructions; a return always ends in its own cycle
    assign instrLastCycle = retiReq | ~slow | (phase == 2'h2);
    assign retiExec       = retiReq;
endmodule // fliv_core_model
`default_nettype wire

// File: verif/fliv_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fliv_ctrl_tb_top;
    import fliv_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, slow = 1'b0, retiReq = 1'b0;
    logic        cfgWrite = 1'b0, powerDown = 1'b0, instrLastCycle, retiExec;
    logic [1:0]  cfgSel = 2'h0;
    logic [17:0] srcFlags = 18'h00000, cfgData = 18'h00000, lo, hi, en, fl;
    logic [7:0]  primaryEnableReg;
    logic [10:0] extendedEnableReg;
    logic [17:0] levelLowBits, levelHighBits, flagAck;
    logic        vecCall, callBusy, handlerStart, wakeReq, got, prevLast;
    logic [15:0] vecAddr;
    logic [4:0]  vecNum, w;
    logic [1:0]  callLevel;
    logic [3:0]  inService;
    integer      seed = 55641;
    int          badCount = 0, checked = 0, cycles = 0;

    fliv_ctrl uut (.clk(clk), .rst_n(rst_n), .srcFlags(srcFlags),
        .instrLastCycle(instrLastCycle), .retiExec(retiExec), .cfgWrite(cfgWrite),
        .cfgSel(cfgSel), .cfgData(cfgData), .powerDown(powerDown),
        .primaryEnableReg(primaryEnableReg), .extendedEnableReg(extendedEnableReg),
        .levelLowBits(levelLowBits), .levelHighBits(levelHighBits), .vecCall(vecCall),
        .callBusy(callBusy), .handlerStart(handlerStart), .vecAddr(vecAddr),
        .vecNum(vecNum), .callLevel(callLevel), .flagAck(flagAck),
        .inService(inService), .wakeReq(wakeReq));
    fliv_core_model core (.clk(clk), .rst_n(rst_n), .slow(slow), .retiReq(retiReq),
        .instrLastCycle(instrLastCycle), .retiExec(retiExec));

    always #50 clk = ~clk;

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            giveVerdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic doReset();
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask

    task automatic cfg(input logic [1:0] sel, input logic [17:0] data);
        cfgWrite = 1'b1;
        cfgSel = sel;
        cfgData = data;
        tick();
        cfgWrite = 1'b0;
        tick();
    endtask

    task automatic noCall(input int n);
        repeat (n) begin
            tick();
            chk(vecCall, 1'b0);
        end
    endtask

    task automatic expectCall(input logic [4:0] vec, input logic [1:0] lvl);
        got = 1'b0;
        for (int i = 0; i < 12 && !got; i++) begin
            prevLast = instrLastCycle;
            tick();
            got = vecCall;
        end
        chk(got, 1'b1);
        chk(prevLast, 1'b1);
        chk(vecNum, vec);
        chk(vecAddr, VEC_BASE + (16'(vec) << VEC_SHIFT));
        chk(callLevel, lvl);
        chk(flagAck, 18'h00001 << vec);
        chk(inService[lvl], 1'b1);
        repeat (3) begin
            tick();
            chk({vecCall, callBusy}, 2'h1);
        end
        tick();
        chk({callBusy, handlerStart}, 2'h1);
    endtask

    task automatic reti(input logic [3:0] expIs);
        retiReq = 1'b1;
        tick();
        retiReq = 1'b0;
        tick();
        chk(inService, expIs);
    endtask

    // Highest level first, natural order breaks ties; 1f means no request
    function automatic logic [4:0] expWin(input logic [17:0] r, input logic [17:0] h,
                                          input logic [17:0] l);
        expWin = 5'h1f;
        for (int lv = 0; lv < 4; lv++) begin
            for (int i = N_SRC - 1; i >= 0; i--) begin
                if (r[NAT_ORDER[i]] && {h[NAT_ORDER[i]], l[NAT_ORDER[i]]} == lv[1:0]) begin
                    expWin = NAT_ORDER[i];
                end
            end
        end
    endfunction

    initial begin
        doReset();
        tick();
        chk({primaryEnableReg, extendedEnableReg}, 19'h0);
        chk(levelLowBits | levelHighBits, 18'h0);
        chk(inService, 4'h0);
        srcFlags = 18'h3ffff;
        noCall(6);
        cfg(2'h1, 18'h007ff);
        cfg(2'h0, 18'h0007f);
        noCall(6);
        slow = 1'b1;
        cfg(2'h0, 18'h000ff);
        expectCall(5'h00, 2'h0);
        srcFlags = 18'h0;
        reti(4'h0);
        slow = 1'b0;
        $display("test enables done");

        for (int k = 0; k < 40; k++) begin
            lo = 18'($random(seed));
            hi = 18'($random(seed));
            en = 18'($random(seed));
            fl = 18'($random(seed));
            if (k == 0) begin
                {lo, hi, en, fl} = {18'h0, 18'h0, 18'h3ffff, 18'h3ffff};
            end
            if (k == 1) begin
                {lo, hi, en, fl} = {18'h3ffff, 18'h3ffff, 18'h3ffff, 18'h3fffe};
            end
            cfg(2'h2, lo);
            cfg(2'h3, hi);
            cfg(2'h1, en[17:7]);
            cfg(2'h0, {1'b1, en[6:0]});
            chk(levelLowBits, lo);
            chk(levelHighBits, hi);
            chk({extendedEnableReg, primaryEnableReg}, {en[17:7], 1'b1, en[6:0]});
            srcFlags = fl;
            w = expWin(fl & en, hi, lo);
            if (w == 5'h1f) begin
                noCall(6);
            end else begin
                expectCall(w, {hi[w], lo[w]});
            end
            srcFlags = 18'h0;
            if (w != 5'h1f) begin
                reti(4'h0);
            end
            cfg(2'h0, 18'h0);
        end
        $display("test arbitration done");

        cfg(2'h2, 18'h00003);
        cfg(2'h3, 18'h00100);
        cfg(2'h1, 18'h007ff);
        cfg(2'h0, 18'h000ff);
        srcFlags = 18'h00002;
        expectCall(5'h01, 2'h1);
        srcFlags = 18'h00005;
        noCall(8);
        srcFlags = 18'h00105;
        expectCall(5'h08, 2'h2);
        chk(inService, 4'h6);
        srcFlags = 18'h00001;
        reti(4'h2);
        noCall(4);
        srcFlags = 18'h0;
        reti(4'h0);
        noCall(8);
        $display("test nesting done");

        powerDown = 1'b1;
        for (int v = 0; v < N_SRC; v++) begin
            srcFlags = 18'h00001 << v;
            tick();
            tick();
            chk(wakeReq, v == 0 || v == 2 || v == 7 || v == 8 || v == 10 || v == 17);
        end
        cfg(2'h0, 18'h0007f);
        tick();
        chk(wakeReq, 1'b0);
        srcFlags = 18'h0;
        powerDown = 1'b0;
        reti(4'h2);
        $display("test wake done");

        cfg(2'h0, 18'h000ff);
        doReset();
        tick();
        chk({primaryEnableReg, extendedEnableReg, inService}, 23'h0);
        $display("test second reset done");
        giveVerdict();
    end
endmodule // fliv_ctrl_tb_top
`default_nettype wire
